/* File: shared/els_defines.vh */
`ifndef ELS_DEFINES_VH
`define ELS_DEFINES_VH

// ==========================================================
// Register offsets (byte addresses)
`define ELS_OFS_MSTATE     4'h0
`define ELS_OFS_SLE        4'h4
`define ELS_OFS_STATUS     4'h8
`define ELS_ADDR_W         4

// ==========================================================
// Machine state register fields
`define ELS_MS_IR_BIT      0
`define ELS_MS_DR_BIT      1
`define ELS_MSTATE_RST     2'h0

// ==========================================================
// Storage little-endian register: one bit per 128 MB region
`define ELS_SLE_RST        32'h00000000
`define ELS_REGION_MSB     31
`define ELS_REGION_LSB     27

// ==========================================================
// Status register fields
`define ELS_ST_FETCH_LE    0
`define ELS_ST_LOAD_LE     1
`define ELS_ST_STORE_LE    2

// ==========================================================
// Access sizes
`define ELS_SZ_BYTE        2'h0
`define ELS_SZ_HALF        2'h1
`define ELS_SZ_WORD        2'h2

`endif

/* File: verilog/els_lane.v */
`include "els_defines.vh"
`default_nettype none

// Registered byte-lane steering with optional extension after the swap
module els_lane (
  input  wire        i_clk,
  input  wire        i_rstn,
  input  wire        i_valid,
  input  wire        i_swap,
  input  wire [1:0]  i_size,
  input  wire        i_sext,
  input  wire [31:0] i_data,
  output reg         o_valid,
  output reg  [31:0] o_data
);

  reg [31:0] lane_d;

  // ==========================================================
  // Swap first, then extend
  always @* begin
    lane_d = i_data;
    case (i_size)
      `ELS_SZ_BYTE: begin
        lane_d = {{24{i_sext & i_data[7]}}, i_data[7:0]};
      end
      `ELS_SZ_HALF: begin
        if (i_swap) begin
          lane_d = {{16{i_sext & i_data[7]}}, i_data[7:0], i_data[15:8]};
        end else begin
          lane_d = {{16{i_sext & i_data[15]}}, i_data[15:0]};
        end
      end
      `ELS_SZ_WORD: begin
        if (i_swap) begin
          lane_d = {i_data[7:0], i_data[15:8], i_data[23:16], i_data[31:24]};
        end else begin
          lane_d = i_data;
        end
      end
      default: begin
        lane_d = i_data;
      end
    endcase
  end

  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_valid <= 1'b0;
      o_data  <= 32'h00000000;
    end else begin
      o_valid <= i_valid;
      if (i_valid) begin
        o_data <= lane_d;
      end
    end
  end

endmodule // els_lane

`default_nettype wire

/* File: verilog/els_top.v */
`include "els_defines.vh"
`default_nettype none

module els_top (
  input  wire        i_clk,
  input  wire        i_rstn,
  // Avalon-MM slave
  input  wire [3:0]  i_avs_address,
  input  wire        i_avs_read,
  input  wire        i_avs_write,
  input  wire [31:0] i_avs_writedata,
  input  wire [3:0]  i_avs_byteenable,
  output reg  [31:0] o_avs_readdata,
  output reg         o_avs_waitrequest,
  // Instruction fetch: memory to instruction cache
  input  wire        i_fetch_valid,
  input  wire [31:0] i_fetch_addr,
  input  wire [31:0] i_fetch_word,
  input  wire        i_fetch_tlb_le,
  output reg         o_icache_valid,
  output reg  [31:0] o_icache_addr,
  output reg  [31:0] o_icache_word,
  output reg         o_fetch_le,
  // Load: data cache to register file
  input  wire        i_ld_valid,
  input  wire [31:0] i_ld_addr,
  input  wire [1:0]  i_ld_size,
  input  wire        i_ld_rev,
  input  wire        i_ld_signed,
  input  wire        i_ld_tlb_le,
  input  wire [31:0] i_ld_data,
  output wire        o_gpr_valid,
  output wire [31:0] o_gpr_data,
  output reg         o_ld_le,
  // Store: register file to data cache
  input  wire        i_st_valid,
  input  wire [31:0] i_st_addr,
  input  wire [1:0]  i_st_size,
  input  wire        i_st_rev,
  input  wire        i_st_tlb_le,
  input  wire [31:0] i_st_data,
  output wire        o_dcache_valid,
  output wire [31:0] o_dcache_data,
  output reg  [31:0] o_dcache_addr,
  output reg         o_st_le
);

  // ==========================================================
  // Registers
  reg [1:0]  machine_state_reg_q;
  reg [31:0] storage_little_endian_reg_q;
  reg [2:0]  status_q;
  reg [31:0] rdata_d;
  wire       instr_relocate;
  wire       data_relocate;
  wire       bus_req;
  wire       bus_take;
  wire       fetch_le;
  wire       ld_le;
  wire       st_le;
  wire       ld_swap;
  wire       st_swap;
  wire       wr_mstate;
  wire       wr_sle;
  wire [31:0] fetch_rev;

  // ==========================================================
  // Relocation enables and bus handshake
  assign instr_relocate = machine_state_reg_q[`ELS_MS_IR_BIT];
  assign data_relocate  = machine_state_reg_q[`ELS_MS_DR_BIT];
  assign bus_req        = i_avs_read | i_avs_write;
  assign bus_take       = bus_req & ~o_avs_waitrequest;

  // ==========================================================
  // Endian flag source selection
  function endian_of;
    input        ir;
    input        dr;
    input        tlb_le;
    input [31:0] sle;
    input [31:0] addr;
    begin
      if (ir | dr) begin
        endian_of = tlb_le;
      end else begin
        endian_of = sle[addr[`ELS_REGION_MSB:`ELS_REGION_LSB]];
      end
    end
  endfunction

  // ==========================================================
  // Bus helpers: byte-enable merge and address match
  function [31:0] merge_be;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  be;
    begin
      merge_be = {be[3] ? nw[31:24] : old[31:24],
                  be[2] ? nw[23:16] : old[23:16],
                  be[1] ? nw[15:8]  : old[15:8],
                  be[0] ? nw[7:0]   : old[7:0]};
    end
  endfunction

  function reg_hit;
    input [`ELS_ADDR_W-1:0] addr;
    input [`ELS_ADDR_W-1:0] ofs;
    begin
      reg_hit = (addr == ofs);
    end
  endfunction

  // ==========================================================
  // Endian attribute per access
  assign fetch_le = endian_of(instr_relocate, data_relocate, i_fetch_tlb_le,
                              storage_little_endian_reg_q, i_fetch_addr);
  assign ld_le    = endian_of(instr_relocate, data_relocate, i_ld_tlb_le,
                              storage_little_endian_reg_q, i_ld_addr);
  assign st_le    = endian_of(instr_relocate, data_relocate, i_st_tlb_le,
                              storage_little_endian_reg_q, i_st_addr);
  assign ld_swap  = ld_le ^ i_ld_rev;
  assign st_swap  = st_le ^ i_st_rev;

  // ==========================================================
  // Register write strobes, taken on the accepting edge
  assign wr_mstate = bus_take & i_avs_write & reg_hit(i_avs_address, `ELS_OFS_MSTATE) &
                     i_avs_byteenable[0];
  assign wr_sle    = bus_take & i_avs_write & reg_hit(i_avs_address, `ELS_OFS_SLE);

  // ==========================================================
  // Avalon slave: one wait cycle, then answer
  always @* begin
    rdata_d = 32'h00000000;
    case (i_avs_address)
      `ELS_OFS_MSTATE: begin
        rdata_d = {30'h00000000, machine_state_reg_q};
      end
      `ELS_OFS_SLE: begin
        rdata_d = storage_little_endian_reg_q;
      end
      `ELS_OFS_STATUS: begin
        rdata_d = {29'h00000000, status_q};
      end
      default: begin
        rdata_d = 32'h00000000;
      end
    endcase
  end

  // ==========================================================
  // Bus response: waitrequest drops for one cycle
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata    <= 32'h00000000;
    end else begin
      if (bus_req && o_avs_waitrequest) begin
        o_avs_waitrequest <= 1'b0;
        o_avs_readdata    <= rdata_d;
      end else begin
        o_avs_waitrequest <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Machine state register: relocation enables
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      machine_state_reg_q <= `ELS_MSTATE_RST;
    end else if (wr_mstate) begin
      machine_state_reg_q <= i_avs_writedata[1:0];
    end
  end

  // ==========================================================
  // Storage little-endian register, merged per byte enable
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      storage_little_endian_reg_q <= `ELS_SLE_RST;
    end else if (wr_sle) begin
      storage_little_endian_reg_q <= merge_be(storage_little_endian_reg_q,
                                              i_avs_writedata, i_avs_byteenable);
    end
  end

  // ==========================================================
  // Instruction word byte reversal, one lane per byte
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_fetch_rev
      assign fetch_rev[8*gi+7:8*gi] = i_fetch_word[31-8*gi:24-8*gi];
    end
  endgenerate

  // ==========================================================
  // Instruction fetch path
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_icache_valid <= 1'b0;
      o_icache_addr  <= 32'h00000000;
      o_icache_word  <= 32'h00000000;
      o_fetch_le     <= 1'b0;
    end else begin
      o_icache_valid <= i_fetch_valid;
      if (i_fetch_valid) begin
        o_icache_addr <= {i_fetch_addr[31:2], 2'h0};
        o_fetch_le    <= fetch_le;
        if (fetch_le) begin
          o_icache_word <= fetch_rev;
        end else begin
          o_icache_word <= i_fetch_word;
        end
      end
    end
  end

  // ==========================================================
  // Load flag: endian attribute of the last load
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_ld_le <= 1'b0;
    end else if (i_ld_valid) begin
      o_ld_le <= ld_le;
    end
  end

  // ==========================================================
  // Store flag and address, address passed through unchanged
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_st_le       <= 1'b0;
      o_dcache_addr <= 32'h00000000;
    end else if (i_st_valid) begin
      o_st_le       <= st_le;
      o_dcache_addr <= i_st_addr;
    end
  end

  // ==========================================================
  // Status: endian flags of the last fetch, load and store
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      status_q <= 3'h0;
    end else begin
      if (i_fetch_valid) begin
        status_q[`ELS_ST_FETCH_LE] <= fetch_le;
      end
      if (i_ld_valid) begin
        status_q[`ELS_ST_LOAD_LE] <= ld_le;
      end
      if (i_st_valid) begin
        status_q[`ELS_ST_STORE_LE] <= st_le;
      end
    end
  end

  // ==========================================================
  // Data paths: swap between data cache and registers
  els_lane u_load (
    .i_clk   (i_clk),
    .i_rstn  (i_rstn),
    .i_valid (i_ld_valid),
    .i_swap  (ld_swap),
    .i_size  (i_ld_size),
    .i_sext  (i_ld_signed),
    .i_data  (i_ld_data),
    .o_valid (o_gpr_valid),
    .o_data  (o_gpr_data)
  );

  els_lane u_store (
    .i_clk   (i_clk),
    .i_rstn  (i_rstn),
    .i_valid (i_st_valid),
    .i_swap  (st_swap),
    .i_size  (i_st_size),
    .i_sext  (1'b0),
    .i_data  (i_st_data),
    .o_valid (o_dcache_valid),
    .o_data  (o_dcache_data)
  );

endmodule // els_top

`default_nettype wire

/* File: tb/els_lane_chk_asserts.sv */
`include "els_defines.vh"
`default_nettype none
// ==========================================================
// Port checks
module els_lane_chk (
  input wire logic        i_clk,
  input wire logic        i_rstn,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic        o_avs_waitrequest,
  input wire logic        i_fetch_valid,
  input wire logic [31:0] i_fetch_addr,
  input wire logic [31:0] i_fetch_word,
  input wire logic        o_icache_valid,
  input wire logic [31:0] o_icache_addr,
  input wire logic [31:0] o_icache_word,
  input wire logic        o_fetch_le,
  input wire logic        i_ld_valid,
  input wire logic [1:0]  i_ld_size,
  input wire logic        i_ld_rev,
  input wire logic        i_ld_signed,
  input wire logic [31:0] i_ld_data,
  input wire logic [31:0] o_gpr_data,
  input wire logic        o_ld_le,
  input wire logic        i_st_valid,
  input wire logic [31:0] i_st_addr,
  input wire logic [31:0] o_dcache_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  function automatic logic [31:0] rv(logic [31:0] w);
    return {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction
  function automatic logic [31:0] hx(logic [31:0] d, logic s);
    return s ? {{16{d[7]}}, d[7:0], d[15:8]} : {{16{d[15]}}, d[15:0]};
  endfunction
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  sequence ans_s;
    !o_avs_waitrequest ##1 o_avs_waitrequest;
  endsequence
  bus_answer_a: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> ans_s)
    else $error("bus answer late");
  fetch_word_a: assert property (i_fetch_valid |=> o_icache_valid && o_icache_word ==
    (o_fetch_le ? rv($past(i_fetch_word)) : $past(i_fetch_word))) else $error("fetch word");
  fetch_addr_a: assert property (i_fetch_valid |=>
    o_icache_addr == ($past(i_fetch_addr) & 32'hfffffffc)) else $error("fetch addr");
  st_addr_a: assert property (i_st_valid |=> o_dcache_addr == $past(i_st_addr))
    else $error("store addr");
  ld_word_a: assert property (i_ld_valid && i_ld_size == `ELS_SZ_WORD |=> o_gpr_data ==
    ((o_ld_le ^ $past(i_ld_rev)) ? rv($past(i_ld_data)) : $past(i_ld_data))) else $error("ld word");
  ld_byte_a: assert property (i_ld_valid && i_ld_size == `ELS_SZ_BYTE |=>
    o_gpr_data == {{24{$past(i_ld_signed) & $past(i_ld_data[7])}}, $past(i_ld_data[7:0])})
    else $error("ld byte");
  ld_half_a: assert property (i_ld_valid && i_ld_size == `ELS_SZ_HALF && i_ld_signed |=>
    o_gpr_data == hx($past(i_ld_data), o_ld_le ^ $past(i_ld_rev))) else $error("ld half");
  fetch_flag_a: assert property (!i_fetch_valid |=> $stable(o_fetch_le))
    else $error("fetch flag moved");
endmodule // els_lane_chk
bind els_top els_lane_chk i_chk (.*);
`default_nettype wire

/* File: tb/els_far.sv */
`default_nettype none
// ==========================================================
// Memory view of one aligned word
module els_far (
  input  wire logic [31:0] i_addr,
  output logic      [31:0] o_word
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] b;
  assign b = {i_addr[7:2], 2'b00};
  assign o_word = {b, b + 8'h1, b + 8'h2, b + 8'h3};
endmodule // els_far
`default_nettype wire

/* File: tb/els_top_test.sv */
`include "els_defines.vh"
`default_nettype none
module els_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0, rstn = 0, rd = 0, wr = 0, fv = 0, lv = 0, sv = 0, rev = 0, sgn = 0;
  logic        tle = 0;
  logic [3:0]  adr = 0, be = 0;
  logic [1:0]  sz = 0, ms_m = 0;
  logic [2:0]  last = 0;
  logic [31:0] wd = 0, addr = 0, dat = 0, sle_m = 0, seed = 32'h14;
  logic [32:0] el, q_l[$];
  logic [64:0] ef, q_f[$];
  logic [96:0] es, q_s[$];
  int          failures = 0, n_checks = 0, cyc = 0;
  wire  [31:0] rdata, iword, iaddr, gdata, ddata, daddr, fword;
  wire         wreq, iv, fle, gv, lle, dv, sle_o;
  els_far i_far (.i_addr(addr), .o_word(fword));
  els_top i_dut (.i_clk(clk), .i_rstn(rstn), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wreq), .i_fetch_valid(fv), .i_fetch_addr(addr), .i_fetch_word(fword),
    .i_fetch_tlb_le(tle), .o_icache_valid(iv), .o_icache_addr(iaddr), .o_icache_word(iword),
    .o_fetch_le(fle), .i_ld_valid(lv), .i_ld_addr(addr), .i_ld_size(sz), .i_ld_rev(rev),
    .i_ld_signed(sgn), .i_ld_tlb_le(tle), .i_ld_data(dat), .o_gpr_valid(gv),
    .o_gpr_data(gdata), .o_ld_le(lle), .i_st_valid(sv), .i_st_addr(addr), .i_st_size(sz),
    .i_st_rev(rev), .i_st_tlb_le(tle), .i_st_data(dat), .o_dcache_valid(dv),
    .o_dcache_data(ddata), .o_dcache_addr(daddr), .o_st_le(sle_o));
  initial forever #2.5 clk = ~clk;
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [31:0] rv(logic [31:0] w);
    return {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction
  function automatic logic [31:0] mw(logic [31:0] a);
    return {a[7:2], 2'b00, a[7:2], 2'b01, a[7:2], 2'b10, a[7:2], 2'b11};
  endfunction
  function automatic logic [31:0] msk(logic [1:0] z);
    return (z == `ELS_SZ_BYTE) ? 32'hff : (z == `ELS_SZ_HALF) ? 32'hffff : 32'hffffffff;
  endfunction
  function automatic logic [31:0] ldx(logic [31:0] d, logic [1:0] z, logic w, logic g);
    logic [15:0] h;
    h = w ? {d[7:0], d[15:8]} : d[15:0];
    if (z == `ELS_SZ_BYTE) return {{24{g & d[7]}}, d[7:0]};
    if (z == `ELS_SZ_HALF) return {{16{g & h[15]}}, h};
    return w ? rv(d) : d;
  endfunction
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ==========================================================
  // Register bus and data traffic
  task automatic bus(logic w, logic [3:0] a, logic [31:0] d, logic [3:0] b, logic [31:0] e);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    be <= b;
    do @(posedge clk); while (wreq !== 1'b0);
    if (!w) chk("readdata", e, rdata);
    rd <= 0;
    wr <= 0;
  endtask
  task automatic op(int k, logic [4:0] rg, logic [1:0] z, logic r);
    logic [31:0] d, ad;
    logic        e, g;
    d = xs();
    ad = xs();
    ad[31:27] = rg;
    g = d[31] & (z != `ELS_SZ_WORD);
    e = (ms_m != 2'h0) ? d[30] : sle_m[rg];
    @(posedge clk);
    fv <= (k == 0);
    lv <= (k == 1);
    sv <= (k == 2);
    addr <= ad;
    dat <= d;
    sz <= z;
    rev <= r;
    tle <= d[30];
    sgn <= g;
    if (k == 0) q_f.push_back({e, (e ? rv(mw(ad)) : mw(ad)), ad[31:2], 2'b00});
    if (k == 1) q_l.push_back({e, ldx(d, z, e ^ r, g)});
    if (k == 2) q_s.push_back({e, msk(z), ldx(d, z, e ^ r, 1'b0), ad});
    last[k] = e;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      wrap_up();
    end
    if (iv === 1'b1) begin
      ef = q_f.pop_front();
      chk("icache_word", ef[63:32], iword);
      chk("icache_addr", ef[31:0], iaddr);
      chk("fetch_le", ef[64], fle);
    end
    if (gv === 1'b1) begin
      el = q_l.pop_front();
      chk("gpr_data", el[31:0], gdata);
      chk("ld_le", el[32], lle);
    end
    if (dv === 1'b1) begin
      es = q_s.pop_front();
      chk("dcache_data", es[63:32], ddata & es[95:64]);
      chk("dcache_addr", es[31:0], daddr);
      chk("st_le", es[96], sle_o);
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1;
    bus(0, 4'h0, 0, 4'hf, 0);
    bus(0, 4'h4, 0, 4'hf, 0);
    bus(1, 4'hc, 32'hffffffff, 4'hf, 0);
    bus(0, 4'hc, 0, 4'hf, 0);
    bus(1, 4'h4, 32'h800000ff, 4'h8, 0);
    sle_m = 32'h80000000;
    bus(0, 4'h4, 0, 4'hf, sle_m);
    // Machine state set before each mode's first fetch, load and store, so the model flag matches
    for (int m = 0; m < 4; m++) begin
      bus(1, 4'h0, m, 4'hf, 0);
      ms_m = m[1:0];
      for (int i = 0; i < 36; i++) begin
        op(i % 3, (i < 18) ? 5'h1f : 5'h00, 2'((i / 3) % 3), (i / 9) % 2 == 1);
      end
      @(posedge clk);
      fv <= 0;
      lv <= 0;
      sv <= 0;
      bus(0, 4'h8, 0, 4'hf, {29'h0, last});
    end
    repeat (3) @(posedge clk);
    chk("pending", 0, q_f.size() + q_l.size() + q_s.size());
    wrap_up();
  end
endmodule // els_top_test
`default_nettype wire
